//--- rtl/dual_hand_initiation.sv
/*
 * Two-hand initiation monitor: asserts the run output only when both
 * hand controls are actuated within the simultaneity window, holds it
 * while both stay actuated, and enforces release of both before a new
 * attempt.
 * Assumes hand inputs are already debounced and synchronous to clk_sys,
 * active high when actuated.
 */
// Function
// RL1: Run only if both pressed within 500ms
// RL2: Window missed: wait for both released
// RL3: Output held only while both held
// RL4: Either release drops the output at once
// RL5: Re-run needs both released, then re-pressed
// RL6: Machine control provides its own anti-repeat
// RL7: Pass-through hazard: configure manual reset instead
// RL8: Window timed by clock counter, set terminal
`include "hand_init_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_hand_initiation
    import hand_init_pkg::*;
#(
    parameter logic [`HI_CNT_W-1:0] WINDOW_CYC = `HI_CNT_W'(`HI_WINDOW_CYC)
) (
    // Clock and reset
    input  wire logic  clk_sys,
    input  wire logic  reset_n,
    // Hand controls, high when actuated
    input  wire logic  hand_a,
    input  wire logic  hand_b,
    // Machine control side
    output logic       run_out,
    output logic       window_fault
);

    hand_state_e state_r;    // Current state
    hand_state_e state_nxt;  // Next state
    logic        both;       // Both hands actuated
    logic        none;       // Both hands released
    logic        expired;    // Window elapsed
    logic        timing;     // Window timer running

    assign both   = hand_a && hand_b;
    assign none   = !hand_a && !hand_b;
    assign timing = (state_r == ST_WAIT);

    // Simultaneity window counter
    window_timer u_timer (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .run      (timing),
        .term_cnt (WINDOW_CYC),
        .expired  (expired)
    );

    // Next-state logic
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                // Both at once starts run; one starts the window
                if (both) begin
                    state_nxt = ST_RUN;      // see RL1
                end else if (!none) begin
                    state_nxt = ST_WAIT;     // see RL8
                end
            end
            ST_WAIT: begin
                // Second hand inside window runs; late goes to lockout
                if (expired) begin
                    state_nxt = ST_LOCKOUT;  // see RL2
                end else if (both) begin
                    state_nxt = ST_RUN;      // see RL1
                end else if (none) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_RUN: begin
                // Any release ends the run
                if (!both) begin
                    state_nxt = ST_LOCKOUT;  // see RL4
                end
            end
            ST_LOCKOUT: begin
                // Only a full release rearms
                if (none) begin
                    state_nxt = ST_IDLE;     // see RL5
                end
            end
            default: begin
                state_nxt = ST_LOCKOUT;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_LOCKOUT;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Run output: on only in run state with both held
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            run_out <= 1'b0;
        end else begin
            run_out <= (state_nxt == ST_RUN);  // see RL3
        end
    end

    // Fault flag: window missed, cleared on full release
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            window_fault <= 1'b0;
        end else if (state_r == ST_WAIT && expired) begin
            window_fault <= 1'b1;  // see RL2
        end else if (none) begin
            window_fault <= 1'b0;
        end
    end

    // Checks below watch the outputs and the state against the rules;
    // they stay silent while reset is held

    // Independent count of cycles spent waiting, kept apart from the
    // timer so that the window length is not judged by the timer itself
    localparam int    LEN_W = `HI_CNT_W + 1;  // One bit over the timer
    logic [LEN_W-1:0] wait_len_r;              // Cycles in wait so far

    // Count wait cycles, clear outside the wait state
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wait_len_r <= '0;
        end else if (state_r == ST_WAIT) begin
            wait_len_r <= wait_len_r + LEN_W'(1);  // see RL8
        end else begin
            wait_len_r <= '0;
        end
    end

    // Output never on unless both held in the previous cycle
    run_both_a: assert property (  // see RL3
        @(posedge clk_sys) disable iff (!reset_n)
        run_out |-> $past(both))
        else $error("run output on without both hands");

    // Output stays on while both stay held
    held_run_a: assert property (  // see RL3
        @(posedge clk_sys) disable iff (!reset_n)
        (run_out && both) |=> run_out)
        else $error("run output dropped while both held");

    // A release drops the output on the next edge
    release_drop_a: assert property (  // see RL4
        @(posedge clk_sys) disable iff (!reset_n)
        (run_out && !both) |=> !run_out)
        else $error("run output not dropped after release");

    // Late second hand never starts a run
    late_block_a: assert property (  // see RL2
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_WAIT && expired) |=> !run_out)
        else $error("run after window expiry");

    // A flagged miss keeps the output off until the flag clears
    fault_norun_a: assert property (  // see RL2
        @(posedge clk_sys) disable iff (!reset_n)
        window_fault |=> !run_out)
        else $error("run output on after a window miss");

    // The miss flag clears once both hands are released
    fault_clear_a: assert property (  // see RL2
        @(posedge clk_sys) disable iff (!reset_n)
        (window_fault && none) |=> !window_fault)
        else $error("window fault kept after full release");

    // Fault flag set when the window is missed
    fault_set_a: assert property (  // see RL2
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_WAIT && expired) |=> window_fault)
        else $error("window fault not flagged");

    // Lockout holds until both released
    lockout_hold_a: assert property (  // see RL5
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_LOCKOUT && !none) |=> (state_r == ST_LOCKOUT))
        else $error("lockout left without full release");

    // Nothing seen in lockout can raise the output
    lockout_off_a: assert property (  // see RL5
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_LOCKOUT) |=> !run_out)
        else $error("run output raised from lockout");

    // Run only starts from idle or wait
    run_entry_a: assert property (  // see RL5
        @(posedge clk_sys) disable iff (!reset_n)
        $rose(run_out) |-> ($past(state_r) == ST_IDLE
                         || $past(state_r) == ST_WAIT))
        else $error("run entered from lockout");

    // Both pressed at once from idle starts a run
    idle_start_a: assert property (  // see RL1
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_IDLE && both) |=> run_out)
        else $error("run not started from idle");

    // Both held in wait before expiry starts a run
    window_ok_a: assert property (  // see RL1
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_WAIT && both && !expired) |=> run_out)
        else $error("run not started inside window");

    // Wait never lasts past the window
    wait_bound_a: assert property (  // see RL8
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_WAIT && expired) |=> (state_r != ST_WAIT))
        else $error("wait state outlived window");

    // Timer expires exactly when the waited cycles reach the window
    window_len_a: assert property (  // see RL8
        @(posedge clk_sys) disable iff (!reset_n)
        (state_r == ST_WAIT)
            |-> (expired == (wait_len_r == {1'b0, WINDOW_CYC})))
        else $error("window length differs from terminal count");

endmodule

`default_nettype wire

//--- pkg/hand_init_cfg.svh
/*
 * Constants for the two-hand initiation monitor: timing of the
 * simultaneity window at the system clock rate.
 * Assumes a 20 MHz system clock.
 */
`ifndef HAND_INIT_CFG_SVH
`define HAND_INIT_CFG_SVH

// System clock period in ns
`define HI_CLK_PERIOD_NS  50
// Simultaneity window in ms
`define HI_WINDOW_MS      500
// Window in clock cycles, rounded down (never longer)
`define HI_WINDOW_CYC     ((`HI_WINDOW_MS * 1000000) / `HI_CLK_PERIOD_NS)
// Counter width for the window
`define HI_CNT_W          24

`endif

//--- pkg/hand_init_pkg.sv
/*
 * Types for the two-hand initiation monitor.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package hand_init_pkg;

    // Monitor states
    typedef enum logic [2:0] {
        ST_IDLE,     // Both released, ready for an attempt
        ST_WAIT,     // One actuated, window running
        ST_RUN,      // Output on
        ST_LOCKOUT   // Waiting for both released
    } hand_state_e;

endpackage

`default_nettype wire

//--- rtl/window_timer.sv
/*
 * Simultaneity window timer: counts system clock cycles while running
 * and flags when the terminal count is reached.
 * Assumes run is held high for the whole wait and low otherwise.
 */
`include "hand_init_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module window_timer (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    // Control
    input  wire logic                  run,
    input  wire logic [`HI_CNT_W-1:0]  term_cnt,
    // Status
    output logic                       expired
);

    logic [`HI_CNT_W-1:0] count_r;  // Elapsed cycles

    // Count while running, clear otherwise; saturate at terminal count
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (!run) begin
            count_r <= '0;
        end else if (count_r < term_cnt) begin
            count_r <= count_r + `HI_CNT_W'(1);  // see RL8
        end
    end

    // Window expired once the count reaches the terminal value
    assign expired = run && (count_r >= term_cnt);  // see RL8

endmodule

`default_nettype wire

//--- tb/hand_pair.sv
/*
 * Behavioural partner: two operator hand controls and the machine
 * control that counts strokes. Assumes the bench sets the intent.
 */
`timescale 1ns/1ps
`default_nettype none

module hand_pair (
    // Clock
    input  wire logic        clk_sys,
    // Operator intent from the bench
    input  wire logic        want_a,
    input  wire logic        want_b,
    // Contacts toward the monitor
    output logic             hand_a,
    output logic             hand_b,
    // Machine control side
    input  wire logic        run_out,
    output logic [7:0]       strokes
);
    // Contacts follow the operator directly
    assign hand_a = want_a;
    assign hand_b = want_b;

    logic run_seen;  // Run output as seen at the previous edge

    // Machine control does its own anti-repeat: one stroke per rise
    initial begin
        strokes  = 8'h00;
        run_seen = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (run_out === 1'b1 && !run_seen) begin
                strokes = strokes + 8'h01;
            end
            run_seen = (run_out === 1'b1);
        end
    end
endmodule

`default_nettype wire

//--- tb/tb_dual_hand_initiation.sv
/*
 * Bench for the two-hand monitor: hand sequences, window hit and miss.
 * Assumes a short window parameter so runs stay brief.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, a); end end

module tb_dual_hand_initiation;
    import hand_init_pkg::*;
    localparam int WIN = 20;              // Short window for simulation
    logic       clk_sys = 1'b0;           // System clock
    logic       reset_n = 1'b0;           // Reset, active low
    logic       want_a  = 1'b0;           // Operator intent A
    logic       want_b  = 1'b0;           // Operator intent B
    logic       hand_a;                   // Contact A
    logic       hand_b;                   // Contact B
    logic       run_out;                  // Initiation output
    logic       window_fault;             // Window missed flag
    logic [7:0] strokes;                  // Machine strokes
    int         errors   = 0;             // Mismatches
    int         n_checks = 0;             // Comparisons

    // 20 MHz clock
    always #25 clk_sys = ~clk_sys;

    // Operator model
    hand_pair u_hands (.clk_sys(clk_sys), .want_a(want_a),
        .want_b(want_b), .hand_a(hand_a), .hand_b(hand_b),
        .run_out(run_out), .strokes(strokes));

    // Monitor under test
    dual_hand_initiation #(.WINDOW_CYC(24'(WIN))) dut (.clk_sys(clk_sys),
        .reset_n(reset_n), .hand_a(hand_a), .hand_b(hand_b),
        .run_out(run_out), .window_fault(window_fault));

    // Wait n falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Set both hands at a falling edge
    task automatic hands(input logic a, input logic b);
        want_a = a;
        want_b = b;
    endtask

    // Hands held through reset must not start a run
    task automatic t_held_reset();
        hands(1'b1, 1'b1);
        cyc(5);
        reset_n = 1'b1;  // Manual reset, apart from initiation
        cyc(4);
        `CHK("run_after_reset", 1'b0, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
    endtask

    // Press inside window, hold, release one, retry with one held
    task automatic t_hit();
        hands(1'b1, 1'b0);
        cyc(WIN - 5);
        hands(1'b1, 1'b1);
        cyc(2);
        `CHK("run_in_window", 1'b1, run_out)
        cyc(10);
        `CHK("run_held", 1'b1, run_out)
        hands(1'b0, 1'b1);
        cyc(2);
        `CHK("run_drop", 1'b0, run_out)
        hands(1'b1, 1'b1);
        cyc(4);
        `CHK("no_rerun_one_held", 1'b0, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
        `CHK("strokes_one", 8'h01, strokes)
    endtask

    // Second hand too late, then release order
    task automatic t_miss();
        hands(1'b0, 1'b1);
        cyc(WIN + 5);
        hands(1'b1, 1'b1);
        cyc(2);
        `CHK("run_late", 1'b0, run_out)
        `CHK("fault_late", 1'b1, window_fault)
        hands(1'b1, 1'b0);
        cyc(3);
        `CHK("fault_one_held", 1'b1, window_fault)
        hands(1'b0, 1'b0);
        cyc(2);
        `CHK("fault_clear", 1'b0, window_fault)
        hands(1'b1, 1'b1);
        cyc(2);
        `CHK("run_new_try", 1'b1, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
    endtask

    // Window end points, release of B alone, lone press dropped in window
    task automatic t_edges();
        hands(1'b1, 1'b0);
        cyc(WIN);
        hands(1'b1, 1'b1);
        cyc(1);
        `CHK("run_last_edge", 1'b1, run_out)
        hands(1'b1, 1'b0);
        cyc(1);
        `CHK("run_drop_b", 1'b0, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
        hands(1'b0, 1'b1);
        cyc(WIN + 1);
        hands(1'b1, 1'b1);
        cyc(1);
        `CHK("run_first_late", 1'b0, run_out)
        `CHK("fault_first_late", 1'b1, window_fault)
        hands(1'b0, 1'b0);
        cyc(2);
        hands(1'b1, 1'b0);
        cyc(3);
        hands(1'b0, 1'b0);
        cyc(2);
        `CHK("fault_lone_drop", 1'b0, window_fault)
        hands(1'b1, 1'b1);
        cyc(1);
        `CHK("run_after_drop", 1'b1, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
    endtask

    // Reset in mid-run drops the output; hands held through it wait
    task automatic t_reset_mid();
        hands(1'b1, 1'b1);
        cyc(2);
        `CHK("run_before_reset", 1'b1, run_out)
        reset_n = 1'b0;
        cyc(1);
        `CHK("run_in_reset", 1'b0, run_out)
        cyc(5);
        reset_n = 1'b1;
        cyc(4);
        `CHK("run_held_reset", 1'b0, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
        hands(1'b1, 1'b1);
        cyc(2);
        `CHK("run_rearmed", 1'b1, run_out)
        hands(1'b0, 1'b0);
        cyc(2);
        `CHK("strokes_total", 8'h06, strokes)
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        cyc(1);
        t_held_reset();
        t_hit();
        t_miss();
        t_edges();
        t_reset_mid();
        report_and_stop();
    end
endmodule

`default_nettype wire
